// ### rtl/cfc_pkg.sv
// Shared constants and types for the changeover fault controller
package cfc_pkg;
  localparam int CFC_MAX_CH = 12;
  localparam int CFC_CH_W = 4;
  localparam int CFC_TYPE_W = 3;
  localparam int CFC_ADDR_W = 8;
  localparam int CFC_DATA_W = 32;
  // Channel types
  localparam logic [2:0] CFC_TYPE_NO_MEAS = 3'h0;
  localparam logic [2:0] CFC_TYPE_DEFAULT = 3'h1;
  // Register offsets
  localparam logic [7:0] CFC_OFF_CTRL = 8'h00;
  localparam logic [7:0] CFC_OFF_CHTYPE = 8'h04;
  localparam logic [7:0] CFC_OFF_STATUS = 8'h08;
  localparam logic [7:0] CFC_OFF_LIVE = 8'h0C;
  localparam logic [7:0] CFC_OFF_CMD = 8'h10;
  // Field positions
  localparam int CFC_CTRL_MANUAL_BIT = 0;
  localparam int CFC_CTRL_REQB_BIT = 1;
  localparam int CFC_CTRL_CNT_LSB = 4;
  localparam int CFC_CMD_CLR_BIT = 0;
  localparam int CFC_CHT_IDX_LSB = 0;
  localparam int CFC_CHT_TYPE_LSB = 8;
  localparam int CFC_ST_SEL_BIT = 0;
  localparam int CFC_ST_MANUAL_BIT = 1;
  localparam int CFC_ST_IND_BIT = 2;
  localparam int CFC_ST_FIXED_BIT = 3;
  localparam int CFC_ST_CH_LSB = 4;
  localparam int CFC_ST_SIDE_BIT = 8;
  localparam int CFC_ST_MENU_LSB = 12;
  localparam int CFC_LIVE_BACK_LSB = 16;
  // Reset values and limits
  localparam logic [3:0] CFC_CNT_MAX = 4'hC;
  localparam logic [3:0] CFC_CNT_RESET = 4'hC;
  localparam logic [3:0] CFC_LAST_IDX = 4'hB;
  localparam logic [3:0] CFC_SAVE_CTRL_IDX = 4'hD;
  localparam logic [3:0] CFC_NVM_CTRL_ADDR = 4'hC;
  // Detector threshold, fixed at build time
  localparam logic [7:0] CFC_DET_THRESH = 8'h40;
  typedef enum logic [1:0] {MS_STANDBY, MS_TOP, MS_SUB, MS_EDIT} cfc_menu_t;
endpackage

// ### rtl/cfc_mem_if.sv
// Channel type memory port between controller and store
`timescale 1ns/1ps
`default_nettype none
interface cfc_mem_if;
  logic we;
  logic [3:0] waddr;
  logic [2:0] wdata;
  logic [3:0] raddr;
  logic [2:0] rdata;
  modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

// ### rtl/cfc_type_mem.sv
// Channel type store with registered read data
`timescale 1ns/1ps
`default_nettype none
module cfc_type_mem
  import cfc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // Memory port
  cfc_mem_if.mem mp
);
  typedef struct packed {
    logic [CFC_MAX_CH-1:0][2:0] ent;
    logic [2:0] rd;
  } cfc_mem_st_t;
  cfc_mem_st_t st_q, st_d;

  always_comb begin
    st_d = st_q;
    if (mp.we && mp.waddr <= CFC_LAST_IDX) begin
      st_d.ent[mp.waddr] = mp.wdata;
    end
    st_d.rd = (mp.raddr <= CFC_LAST_IDX) ? st_q.ent[mp.raddr] : CFC_TYPE_NO_MEAS;
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= '{ent: {CFC_MAX_CH{CFC_TYPE_DEFAULT}}, rd: CFC_TYPE_NO_MEAS};
    end else begin
      st_q <= st_d;
    end
  end

  assign mp.rdata = st_q.rd;
endmodule
`default_nettype wire

// ### rtl/cfc_ctrl.sv
// Changeover controller: fault latching, common select, menu and settings save
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Losing power drops the common select to primary on every channel.
// - Active channels are channels 1 up to the channel count.
// - Channel count is limited to twelve.
// - Active channel without signal reports input missing continuously.
// - An error on any monitored channel can trigger the changeover.
// - All channels switch together from one common select.
// - Automatic mode switches source on faults without operator action.
// - Manual mode switches only on operator choice, never on faults.
// - Unmonitored relay channels follow the same select, unchecked.
// - Each output carries primary or backup per mode and configuration.
// - Detection thresholds are fixed constants, not adjustable.
// - Fault on primary or backup of a configured channel raises indication.
// - Fault indication latches after an intermittent fault recovers.
// - Only the lowest-numbered faulty configured channel is reported.
// - After repair the report moves to the next faulty channel.
// - After last repair show fixed until operator clears; clear turns off.
// - Returning to standby saves changed settings to non-volatile store.
// - No-measurement channels are not checked, only switched.
// - Back press moves menu up one level to standby; at standby it opens the top menu.
// - Rotary press enters edit, leaves edit, or descends one level.
// - Auto select table: none P, P fault B, B fault P, both B.
// - Auto mode returns to primary once primary fault is repaired.
// - Backup request is accepted only in manual mode.
module cfc_ctrl
  import cfc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // Register port
  input wire logic [CFC_ADDR_W-1:0] reg_addr_in,
  input wire logic [CFC_DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [CFC_DATA_W-1:0] reg_rdata_out,
  // Detector and panel pins
  input wire logic [CFC_MAX_CH-1:0] prim_ok_in,
  input wire logic [CFC_MAX_CH-1:0] back_ok_in,
  input wire logic power_ok_in,
  input wire logic btn_back_in,
  input wire logic btn_press_in,
  // Saved settings load
  input wire logic nvm_load_in,
  input wire logic [3:0] nvm_load_count_in,
  // Saved settings store
  output logic nvm_we_out,
  output logic [3:0] nvm_addr_out,
  output logic [CFC_DATA_W-1:0] nvm_data_out,
  // Switching and display
  output logic [CFC_MAX_CH-1:0] ch_backup_out,
  output logic follower_backup_out,
  output logic fault_ind_out,
  output logic [7:0] det_thresh_out
);
  localparam int SYNC_W = 2 * CFC_MAX_CH + 3;
  // Synchronisers start at the idle pin levels: power good, buttons up, inputs present,
  // so the first edges after reset raise no false fault
  localparam logic [SYNC_W-1:0] SYNC_IDLE = {1'b1, 1'b0, 1'b0, {(2 * CFC_MAX_CH){1'b1}}};

  typedef struct packed {
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic [1:0] btn_prev;
    logic manual;
    logic req_backup;
    logic [3:0] cnt;
    logic sel_backup;
    logic relay;
    logic seen;
    cfc_menu_t menu;
    logic dirty;
    logic [3:0] scan;
    logic [3:0] rd_idx;
    logic rd_sv;
    logic [CFC_MAX_CH-1:0] nomeas;
    logic saving;
    logic [3:0] sv_idx;
    logic nvm_we;
    logic [3:0] nvm_addr;
    logic [CFC_DATA_W-1:0] nvm_data;
    logic [CFC_DATA_W-1:0] rdata;
    logic [CFC_DATA_W-1:0] cht_shadow;
  } cfc_st_t;

  cfc_st_t st_q, st_d;
  cfc_mem_if mif();

  logic [CFC_MAX_CH-1:0] p_ok_s, b_ok_s;
  logic pwr_s, back_s, press_s;
  logic [CFC_MAX_CH-1:0] active, p_flt, b_flt;
  logic any_p, any_b, any_live, fixed;
  logic [3:0] rep_ch;
  logic rep_side;
  logic back_ev, press_ev;
  logic clr_req;
  logic cfg_wr;
  logic [3:0] wr_cnt;
  logic [CFC_DATA_W-1:0] ctrl_word, status_word, live_word;

  cfc_type_mem u_mem (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .mp(mif.mem)
  );

  // Second synchroniser stage feeds all logic
  assign {pwr_s, back_s, press_s, b_ok_s, p_ok_s} = st_q.sync2;
  assign back_ev = back_s && !st_q.btn_prev[1];
  assign press_ev = press_s && !st_q.btn_prev[0];

  // Per-channel monitoring
  generate
    for (genvar i = 0; i < CFC_MAX_CH; i++) begin : g_ch
      assign active[i] = (4'(i) < st_q.cnt) && !st_q.nomeas[i];
      assign p_flt[i] = active[i] && !p_ok_s[i];
      assign b_flt[i] = active[i] && !b_ok_s[i];
      assign ch_backup_out[i] = st_q.relay;
    end
  endgenerate

  assign any_p = |p_flt;
  assign any_b = |b_flt;
  assign any_live = any_p || any_b;
  // Fixed: a fault was seen and none is live now
  assign fixed = st_q.seen && !any_live;

  // Lowest-numbered faulty channel wins
  always_comb begin
    rep_ch = 4'h0;
    rep_side = 1'b0;
    for (int i = CFC_MAX_CH - 1; i >= 0; i--) begin
      if (p_flt[i] || b_flt[i]) begin
        rep_ch = 4'(i + 1);
        rep_side = !p_flt[i];
      end
    end
  end

  assign wr_cnt = reg_wdata_in[CFC_CTRL_CNT_LSB +: 4];
  // Any settings write marks the saved copy stale
  assign cfg_wr = reg_wr_in && (reg_addr_in == CFC_OFF_CTRL || reg_addr_in == CFC_OFF_CHTYPE);
  // Clear comes from the command register or a press on the standby screen
  assign clr_req = (reg_wr_in && reg_addr_in == CFC_OFF_CMD && reg_wdata_in[CFC_CMD_CLR_BIT])
                   || (press_ev && st_q.menu == MS_STANDBY && fixed);

  // Readable views of control, status and live faults
  always_comb begin
    ctrl_word = '0;
    ctrl_word[CFC_CTRL_MANUAL_BIT] = st_q.manual;
    ctrl_word[CFC_CTRL_REQB_BIT] = st_q.req_backup;
    ctrl_word[CFC_CTRL_CNT_LSB +: 4] = st_q.cnt;
    status_word = '0;
    status_word[CFC_ST_SEL_BIT] = st_q.sel_backup;
    status_word[CFC_ST_MANUAL_BIT] = st_q.manual;
    status_word[CFC_ST_IND_BIT] = any_live || st_q.seen;
    status_word[CFC_ST_FIXED_BIT] = fixed;
    status_word[CFC_ST_CH_LSB +: 4] = rep_ch;
    status_word[CFC_ST_SIDE_BIT] = rep_side;
    status_word[CFC_ST_MENU_LSB +: 2] = st_q.menu;
    live_word = '0;
    live_word[CFC_MAX_CH-1:0] = p_flt;
    live_word[CFC_LIVE_BACK_LSB +: CFC_MAX_CH] = b_flt;
  end

  always_comb begin
    st_d = st_q;
    st_d.sync1 = {power_ok_in, btn_back_in, btn_press_in, back_ok_in, prim_ok_in};
    st_d.sync2 = st_q.sync1;
    st_d.btn_prev = {back_s, press_s};
    st_d.nvm_we = 1'b0;

    // Register writes
    if (reg_wr_in) begin
      if (reg_addr_in == CFC_OFF_CTRL) begin
        st_d.manual = reg_wdata_in[CFC_CTRL_MANUAL_BIT];
        // Backup request only taken in manual mode
        if (reg_wdata_in[CFC_CTRL_MANUAL_BIT]) begin
          st_d.req_backup = reg_wdata_in[CFC_CTRL_REQB_BIT];
        end else begin
          st_d.req_backup = 1'b0;
        end
        st_d.cnt = (wr_cnt > CFC_CNT_MAX) ? CFC_CNT_MAX : wr_cnt;
        st_d.dirty = 1'b1;
      end else if (reg_addr_in == CFC_OFF_CHTYPE) begin
        st_d.cht_shadow = reg_wdata_in;
        st_d.dirty = 1'b1;
      end
    end

    // Loaded settings restart in auto on primary
    if (nvm_load_in) begin
      st_d.cnt = (nvm_load_count_in > CFC_CNT_MAX) ? CFC_CNT_MAX : nvm_load_count_in;
      st_d.manual = 1'b0;
      st_d.req_backup = 1'b0;
      st_d.sel_backup = 1'b0;
    end else if (st_q.manual) begin
      st_d.sel_backup = st_q.req_backup;
    end else begin
      // Primary fault forces backup; otherwise primary
      st_d.sel_backup = any_p;
    end
    // Relays fall to primary without power
    st_d.relay = st_d.sel_backup && pwr_s;

    // Fault latch: a new fault wins over a clear
    if (any_live) begin
      st_d.seen = 1'b1;
    end else if (clr_req) begin
      st_d.seen = 1'b0;
    end

    // Menu navigation
    case (st_q.menu)
      MS_STANDBY: begin
        // A press while fixed clears the fault instead of entering the menu
        if (back_ev || (press_ev && !fixed)) begin
          st_d.menu = MS_TOP;
        end
      end
      MS_TOP: begin
        if (back_ev) begin
          st_d.menu = MS_STANDBY;
          if (st_q.dirty) begin
            st_d.saving = 1'b1;
            st_d.sv_idx = 4'h0;
            // A settings write in this very cycle keeps the copy stale
            st_d.dirty = cfg_wr;
          end
        end else if (press_ev) begin
          st_d.menu = MS_SUB;
        end
      end
      MS_SUB: begin
        if (back_ev) begin
          st_d.menu = MS_TOP;
        end else if (press_ev) begin
          st_d.menu = MS_EDIT;
        end
      end
      MS_EDIT: begin
        if (back_ev || press_ev) begin
          st_d.menu = MS_SUB;
        end
      end
      default: st_d.menu = MS_STANDBY;
    endcase

    // Type memory read pipeline: scan builds the unchecked mask, save walks entries
    st_d.rd_idx = st_q.saving ? st_q.sv_idx : st_q.scan;
    st_d.rd_sv = st_q.saving && st_q.sv_idx <= CFC_LAST_IDX;
    // Scan pauses while a save walks the store
    if (!st_q.saving) begin
      st_d.scan = (st_q.scan == CFC_LAST_IDX) ? 4'h0 : st_q.scan + 4'h1;
    end
    if (st_q.rd_sv) begin
      st_d.nvm_we = 1'b1;
      st_d.nvm_addr = st_q.rd_idx;
      st_d.nvm_data = {{(CFC_DATA_W - CFC_TYPE_W){1'b0}}, mif.rdata};
    end else if (st_q.rd_idx <= CFC_LAST_IDX) begin
      st_d.nomeas[st_q.rd_idx] = (mif.rdata == CFC_TYPE_NO_MEAS);
    end
    if (st_q.saving) begin
      // The control word goes out right after the last entry
      if (st_q.sv_idx == CFC_SAVE_CTRL_IDX) begin
        st_d.saving = 1'b0;
        st_d.nvm_we = 1'b1;
        st_d.nvm_addr = CFC_NVM_CTRL_ADDR;
        st_d.nvm_data = ctrl_word;
      end else begin
        st_d.sv_idx = st_q.sv_idx + 4'h1;
      end
    end

    // Register reads
    // Read data stand for one cycle only, zero otherwise
    st_d.rdata = '0;
    if (reg_rd_in) begin
      if (reg_addr_in == CFC_OFF_CTRL) begin
        st_d.rdata = ctrl_word;
      end else if (reg_addr_in == CFC_OFF_CHTYPE) begin
        st_d.rdata = st_q.cht_shadow;
      end else if (reg_addr_in == CFC_OFF_STATUS) begin
        st_d.rdata = status_word;
      end else if (reg_addr_in == CFC_OFF_LIVE) begin
        st_d.rdata = live_word;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= '{
        sync1: SYNC_IDLE,
        sync2: SYNC_IDLE,
        // Buttons count as held for the first cycle only; a press held across reset still acts two cycles later
        btn_prev: 2'h3,
        manual: 1'b0,
        req_backup: 1'b0,
        cnt: CFC_CNT_RESET,
        sel_backup: 1'b0,
        relay: 1'b0,
        seen: 1'b0,
        menu: MS_STANDBY,
        dirty: 1'b0,
        scan: 4'h0,
        rd_idx: 4'h0,
        rd_sv: 1'b0,
        nomeas: '0,
        saving: 1'b0,
        sv_idx: 4'h0,
        nvm_we: 1'b0,
        nvm_addr: 4'h0,
        nvm_data: '0,
        rdata: '0,
        cht_shadow: '0
      };
    end else begin
      st_q <= st_d;
    end
  end

  // Bus writes to the type store go straight to the memory
  assign mif.we = reg_wr_in && reg_addr_in == CFC_OFF_CHTYPE;
  assign mif.waddr = reg_wdata_in[CFC_CHT_IDX_LSB +: 4];
  assign mif.wdata = reg_wdata_in[CFC_CHT_TYPE_LSB +: CFC_TYPE_W];
  assign mif.raddr = st_q.saving ? st_q.sv_idx : st_q.scan;

  // Outputs straight from state; threshold from the package constant
  assign reg_rdata_out = st_q.rdata;
  assign nvm_we_out = st_q.nvm_we;
  assign nvm_addr_out = st_q.nvm_addr;
  assign nvm_data_out = st_q.nvm_data;
  assign follower_backup_out = st_q.relay;
  assign fault_ind_out = st_q.seen;
  assign det_thresh_out = CFC_DET_THRESH;
endmodule
`default_nettype wire

// ### tb/cfc_ctrl_chk.sv
// Port checker for the changeover controller
`timescale 1ns/1ps
`default_nettype none
module cfc_ctrl_chk
  import cfc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // Watched inputs
  input wire logic [CFC_ADDR_W-1:0] reg_addr_in,
  input wire logic [CFC_DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic [CFC_MAX_CH-1:0] prim_ok_in,
  input wire logic power_ok_in,
  input wire logic btn_press_in,
  input wire logic nvm_load_in,
  input wire logic [3:0] nvm_load_count_in,
  // Watched outputs
  input wire logic nvm_we_out,
  input wire logic [3:0] nvm_addr_out,
  input wire logic [CFC_MAX_CH-1:0] ch_backup_out,
  input wire logic follower_backup_out,
  input wire logic fault_ind_out,
  input wire logic [7:0] det_thresh_out
);
  logic man_q;
  logic req_q;
  logic [3:0] cnt_q;
  logic [3:0] clr_q;
  logic [4:0] age_q;
  logic [CFC_MAX_CH-1:0] meas_q;
  logic [CFC_MAX_CH-1:0] act_w;
  logic pf_w;
  wire ctl_w = reg_wr_in && reg_addr_in == CFC_OFF_CTRL;
  wire cht_w = reg_wr_in && reg_addr_in == CFC_OFF_CHTYPE;
  wire clr_w = btn_press_in || (reg_wr_in && reg_addr_in == CFC_OFF_CMD);
  // Shadow of the mode and channel set, so the select can be predicted
  always_comb begin
    for (int i = 0; i < CFC_MAX_CH; i++) begin
      act_w[i] = (i < cnt_q) && meas_q[i];
    end
    pf_w = |(act_w & ~prim_ok_in);
  end
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      man_q <= 1'b0;
      req_q <= 1'b0;
      cnt_q <= CFC_CNT_RESET;
      meas_q <= '1;
      age_q <= 5'h00;
      clr_q <= 4'hF;
    end else begin
      age_q <= (ctl_w || cht_w || nvm_load_in) ? 5'h00 : age_q + {4'h0, age_q != 5'h1F};
      clr_q <= clr_w ? 4'h0 : clr_q + {3'h0, clr_q != 4'hF};
      if (nvm_load_in) begin
        man_q <= 1'b0;
        req_q <= 1'b0;
        cnt_q <= (nvm_load_count_in > CFC_CNT_MAX) ? CFC_CNT_MAX : nvm_load_count_in;
      end else if (ctl_w) begin
        man_q <= reg_wdata_in[0];
        req_q <= reg_wdata_in[0] & reg_wdata_in[1];
        cnt_q <= (reg_wdata_in[7:4] > CFC_CNT_MAX) ? CFC_CNT_MAX : reg_wdata_in[7:4];
      end
      if (cht_w && reg_wdata_in[3:0] <= CFC_LAST_IDX) begin
        meas_q[reg_wdata_in[3:0]] <= reg_wdata_in[10:8] != CFC_TYPE_NO_MEAS;
      end
    end
  end
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  sequence s_settled;
    (power_ok_in && $stable(prim_ok_in)) [*6];
  endsequence
  sequence s_save_step;
    nvm_we_out && nvm_addr_out < CFC_LAST_IDX;
  endsequence
  sequence s_save_tail;
    (nvm_we_out && nvm_addr_out == CFC_NVM_CTRL_ADDR) ##1 !nvm_we_out;
  endsequence
  a_one_select: assert property (ch_backup_out == '0 || ch_backup_out == '1)
    else $error("channel selects differ");
  a_follow_sel: assert property (follower_backup_out == ch_backup_out[0])
    else $error("follower select differs");
  a_fixed_thresh: assert property (det_thresh_out == CFC_DET_THRESH)
    else $error("threshold changed");
  a_power_loss: assert property (!power_ok_in [*5] |-> ch_backup_out == '0)
    else $error("backup routed without power");
  a_fault_latch: assert property ($fell(fault_ind_out) |-> clr_q < 4'hC)
    else $error("indication dropped without clear");
  a_manual_hold: assert property (s_settled ##0 (man_q && age_q > 5'h03) |-> ch_backup_out[0] == req_q)
    else $error("manual select wrong");
  a_auto_table: assert property (s_settled ##0 (!man_q && age_q == 5'h1F) |-> ch_backup_out[0] == pf_w)
    else $error("auto select wrong");
  a_save_order: assert property (s_save_step |=> nvm_we_out && nvm_addr_out == $past(nvm_addr_out) + 4'h1)
    else $error("save address skipped");
  a_save_tail: assert property (nvm_we_out && nvm_addr_out == CFC_LAST_IDX |=> s_save_tail)
    else $error("save tail wrong");
endmodule
bind cfc_ctrl cfc_ctrl_chk cfc_ctrl_chk_i (.ref_clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in,
  .reg_wr_in, .prim_ok_in, .power_ok_in, .btn_press_in, .nvm_load_in, .nvm_load_count_in,
  .nvm_we_out, .nvm_addr_out,
  .ch_backup_out, .follower_backup_out, .fault_ind_out, .det_thresh_out);
`default_nettype wire

// ### tb/cfc_src_model.sv
// Signal generators, mains feed and front panel operator
`timescale 1ns/1ps
`default_nettype none
module cfc_src_model
  import cfc_pkg::*;
(
  // Clock
  input wire logic clk_in,
  // Bench commands
  input wire logic [CFC_MAX_CH-1:0] prim_lost_in,
  input wire logic [CFC_MAX_CH-1:0] back_lost_in,
  input wire logic mains_off_in,
  input wire logic slow_in,
  input wire logic push_in,
  input wire logic back_in,
  // Pins toward the controller
  output logic [CFC_MAX_CH-1:0] prim_ok_out,
  output logic [CFC_MAX_CH-1:0] back_ok_out,
  output logic power_ok_out,
  output logic btn_press_out,
  output logic btn_back_out
);
  logic [2*CFC_MAX_CH:0] pipe_q [3];
  logic [3:0] push_q = 4'h0;
  logic [3:0] back_q = 4'h0;
  wire [2*CFC_MAX_CH:0] cmd_w = {mains_off_in, back_lost_in, prim_lost_in};
  // A slow source reacts three cycles late
  wire [2*CFC_MAX_CH:0] now_w = slow_in ? pipe_q[2] : cmd_w;
  always_ff @(posedge clk_in) begin
    pipe_q[0] <= cmd_w;
    pipe_q[1] <= pipe_q[0];
    pipe_q[2] <= pipe_q[1];
    push_q <= push_in ? 4'hF : push_q >> 1;
    back_q <= back_in ? 4'hF : back_q >> 1;
  end
  assign prim_ok_out = ~now_w[CFC_MAX_CH-1:0];
  assign back_ok_out = ~now_w[2*CFC_MAX_CH-1:CFC_MAX_CH];
  assign power_ok_out = ~now_w[2*CFC_MAX_CH];
  assign btn_press_out = push_q[0];
  assign btn_back_out = back_q[0];
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the changeover controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import cfc_pkg::*;
  logic clk;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_seen = 1'b0;
  logic [31:0] rdata;
  logic [11:0] lost_p = 12'h000;
  logic [11:0] lost_b = 12'h000;
  logic off = 1'b0;
  logic slow = 1'b0;
  logic push = 1'b0;
  logic bk = 1'b0;
  logic ld = 1'b0;
  logic [3:0] ld_cnt = 4'h0;
  logic [11:0] pok;
  logic [11:0] bok;
  logic pwr, bp, bb, nvm_we, fol, ind;
  logic [3:0] nvm_addr;
  logic [31:0] nvm_data, r, save_ctl, save_t2;
  logic [11:0] chb;
  logic [7:0] thr;
  logic [2:0] steps [6] = '{3'h5, 3'h6, 3'h7, 3'h2, 3'h1, 3'h0};
  logic [31:0] exp_q [$];
  int seed = 13;
  int n_mismatch = 0;
  int total_checks = 0;
  int n_save = 0;
  cfc_ctrl cfc_ctrl_i (.ref_clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .prim_ok_in(pok), .back_ok_in(bok),
    .power_ok_in(pwr), .btn_back_in(bb), .btn_press_in(bp), .nvm_load_in(ld),
    .nvm_load_count_in(ld_cnt), .nvm_we_out(nvm_we), .nvm_addr_out(nvm_addr),
    .nvm_data_out(nvm_data), .ch_backup_out(chb), .follower_backup_out(fol),
    .fault_ind_out(ind), .det_thresh_out(thr));
  cfc_src_model cfc_src_model_i (.clk_in(clk), .prim_lost_in(lost_p), .back_lost_in(lost_b),
    .mains_off_in(off), .slow_in(slow), .push_in(push), .back_in(bk), .prim_ok_out(pok),
    .back_ok_out(bok), .power_ok_out(pwr), .btn_press_out(bp), .btn_back_out(bb));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  // Reads note the masked expectation; the watcher compares the masked answer
  task automatic rreg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e & m);
    exp_q.push_back(m);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic pr(input logic b);
    push <= b;
    bk <= !b;
    @(posedge clk);
    push <= 1'b0;
    bk <= 1'b0;
    wt(12);
  endtask
  function automatic logic [31:0] st(input logic s, m, i, f, input logic [3:0] c, input logic sd);
    return {23'h0, sd, c, f, i, m, s};
  endfunction
  always @(posedge clk) begin
    if (rd_seen && exp_q.size() > 1) begin
      check(rdata & exp_q[1], exp_q[0]);
      void'(exp_q.pop_front());
      void'(exp_q.pop_front());
    end
    rd_seen <= rd;
    if (nvm_we) begin
      n_save++;
      if (nvm_addr == CFC_NVM_CTRL_ADDR) save_ctl = nvm_data;
      if (nvm_addr == 4'h2) save_t2 = nvm_data;
    end
  end
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    test_done();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    wt(5);
    rreg(CFC_OFF_CTRL, {24'h0, CFC_CNT_RESET, 4'h0}, 32'hFF);
    rreg(CFC_OFF_STATUS, 32'h0, 32'h31FF);
    check({24'h0, thr}, {24'h0, CFC_DET_THRESH});
    check({20'h0, chb}, 32'h0);
    $display("test reset done");
    wreg(CFC_OFF_CTRL, 32'hF0);
    rreg(CFC_OFF_CTRL, 32'hC0, 32'hF3);
    wreg(CFC_OFF_CTRL, 32'h30);
    wreg(CFC_OFF_CHTYPE, {21'h0, CFC_TYPE_NO_MEAS, 8'h02});
    rreg(CFC_OFF_CHTYPE, {21'h0, CFC_TYPE_NO_MEAS, 8'h02}, 32'hFFFFFFFF);
    wt(20);
    r = $random(seed);
    lost_p <= (r[11:0] & 12'hFF8) | 12'h004;
    wt(20);
    rreg(CFC_OFF_STATUS, 32'h0, 32'hF);
    rreg(CFC_OFF_LIVE, 32'h0, 32'hFFFFFFFF);
    $display("test range done");
    lost_b <= 12'h002;
    wt(20);
    rreg(CFC_OFF_STATUS, st(0, 0, 1, 0, 4'h2, 1), 32'h31FF);
    rreg(CFC_OFF_LIVE, 32'h00020000, 32'hFFFFFFFF);
    lost_p <= (r[11:0] & 12'hFF8) | 12'h005;
    wt(20);
    rreg(CFC_OFF_STATUS, st(1, 0, 1, 0, 4'h1, 0), 32'h31FF);
    check({20'h0, chb}, 32'hFFF);
    check({31'h0, fol}, 32'h1);
    lost_p <= (r[11:0] & 12'hFF8) | 12'h004;
    wt(20);
    rreg(CFC_OFF_STATUS, st(0, 0, 1, 0, 4'h2, 1), 32'h31FF);
    lost_b <= 12'h000;
    wt(20);
    rreg(CFC_OFF_STATUS, st(0, 0, 1, 1, 4'h0, 0), 32'h31FF);
    check({31'h0, ind}, 32'h1);
    wreg(CFC_OFF_CMD, 32'h1);
    wt(4);
    rreg(CFC_OFF_STATUS, 32'h0, 32'hF);
    check({31'h0, ind}, 32'h0);
    $display("test auto done");
    wreg(CFC_OFF_CTRL, 32'h31);
    slow <= 1'b1;
    lost_p <= (r[11:0] & 12'hFF8) | 12'h005;
    wt(20);
    check({20'h0, chb}, 32'h0);
    rreg(CFC_OFF_STATUS, st(0, 1, 1, 0, 4'h1, 0), 32'h31FF);
    wreg(CFC_OFF_CTRL, 32'h33);
    wt(4);
    check({20'h0, chb}, 32'hFFF);
    wreg(CFC_OFF_CTRL, 32'h32);
    rreg(CFC_OFF_CTRL, 32'h30, 32'hF3);
    wt(20);
    check({20'h0, chb}, 32'hFFF);
    off <= 1'b1;
    wt(12);
    check({20'h0, chb}, 32'h0);
    off <= 1'b0;
    lost_p <= (r[11:0] & 12'hFF8) | 12'h004;
    wt(20);
    rreg(CFC_OFF_STATUS, st(0, 0, 1, 1, 4'h0, 0), 32'h31FF);
    pr(1'b1);
    rreg(CFC_OFF_STATUS, 32'h0, 32'h300F);
    $display("test manual done");
    for (int k = 0; k < 6; k++) begin
      pr(steps[k][2]);
      rreg(CFC_OFF_STATUS, {18'h0, steps[k][1:0], 12'h0}, 32'h3000);
    end
    wt(20);
    check(n_save, 32'd13);
    check(save_ctl & 32'hF3, 32'h30);
    check(save_t2 & 32'h7, {29'h0, CFC_TYPE_NO_MEAS});
    $display("test menu done");
    lost_p <= 12'h000;
    wreg(CFC_OFF_CTRL, 32'h33);
    wt(8);
    check({20'h0, chb}, 32'hFFF);
    ld_cnt <= 4'hF;
    ld <= 1'b1;
    @(posedge clk);
    ld <= 1'b0;
    wt(4);
    rreg(CFC_OFF_CTRL, 32'hC0, 32'hF3);
    check({20'h0, chb}, 32'h0);
    $display("test load done");
    test_done();
  end
endmodule
`default_nettype wire
